//--- common/alu_defs.vh
/*
 * Constants for the unsigned packed-halving and long-multiply datapath:
 * operation codes, lane widths and lane field positions.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef ALU_DEFS_VH
`define ALU_DEFS_VH

// Operation select codes
`define OP_W              3
`define OP_HSUB_ADD_XCH   3'h0
`define OP_HSUB_HALF      3'h1
`define OP_HSUB_BYTE      3'h2
`define OP_MUL_DACC_LONG  3'h3
`define OP_MUL_ACC_LONG   3'h4
`define OP_MUL_LONG       3'h5
`define OP_QADD_HALF      3'h6
`define OP_QADD_BYTE      3'h7

// Word, lane and register number widths
`define WORD_W            32
`define DWORD_W           64
`define HALF_W            16
`define BYTE_W            8
`define HALF_LANES        2
`define BYTE_LANES        4
`define REGNUM_W          4

// Field positions
`define HALF_LO           15:0
`define HALF_HI           31:16
`define DWORD_LO          31:0
`define DWORD_HI          63:32

// Reset values
`define WORD_RST          32'h00000000
`define REGNUM_RST        4'h0

`endif

//--- design/unsigned_simd_halving_multiply_alu.v
/*
 * Execution datapath for unsigned halving subtracts, saturating adds and
 * 32x32 long multiplies, with one registered stage of write-back.
 * Assumes the decode logic supplies operands already read from the register
 * file, the prior destination contents for the accumulating multiplies, and
 * a condition-pass level, all in the core_clk domain. Legal register numbers
 * are the issuer's responsibility; this block does not check them.
 * Results leave one clock after the issuing edge and stand for one cycle;
 * the register file must absorb both write ports in that same cycle.
 * Data and number outputs read zero whenever their enable is low, so a
 * watcher can compare them without looking at the enables first.
 * The flag strobes are outputs only to show that no flag write happens.
 */
`include "alu_defs.vh"

// Notes on behaviour
// RULE_01: Exchange op: low half a.lo plus b.hi, high half a.hi minus b.lo, halved.
// RULE_02: Halfword halving subtract: per lane 17-bit difference shifted right one.
// RULE_03: Byte halving subtract: four 9-bit differences, keep bits eight to one.
// RULE_04: Double accumulate: product plus prior low plus prior high, 64 bits.
// RULE_05: Long multiplies write bits 31:0 to low dest, 63:32 to high dest.
// RULE_06: Accumulate long: product plus {high,low}, carry beyond bit 63 dropped.
// RULE_07: Plain long multiply: full 64-bit product, no accumulation.
// RULE_08: Accumulate long and plain long multiply never write condition flags.
// RULE_09: Issuer must not give equal high and low destination numbers.
// RULE_10: Issuer must not use register 13 or 15 in a long multiply.
// RULE_11: Issuer must not use register 13 or 15 in packed operations.
// RULE_12: Halfword saturating add: each lane sum clamped to 0..65535.
// RULE_13: Byte saturating add: each lane sum clamped to 0..255.
// RULE_14: Failed condition check writes nothing and changes no state.
// RULE_15: Packed ops leave flags and GE flags alone; only dest written.
module unsigned_simd_halving_multiply_alu #(
    // Datapath and register number widths
    parameter DATA_W   = `WORD_W,
    parameter REGNUM_W = `REGNUM_W
) (
    // Clock and reset
    input  wire                  core_clk,
    input  wire                  nrst,
    // Issue from decode
    input  wire                  issue_valid,
    input  wire                  cond_passed,
    input  wire [`OP_W-1:0]      op_sel,
    // Operands and prior destination contents
    input  wire [DATA_W-1:0]     first_operand,
    input  wire [DATA_W-1:0]     second_operand,
    input  wire [DATA_W-1:0]     acc_low,
    input  wire [DATA_W-1:0]     acc_high,
    // Destination register numbers
    input  wire [REGNUM_W-1:0]   dest_reg,
    input  wire [REGNUM_W-1:0]   dest_low_reg,
    input  wire [REGNUM_W-1:0]   dest_high_reg,
    // Write-back port 0: packed result or low word
    output reg                   wr0_en,
    output reg  [REGNUM_W-1:0]   wr0_num,
    output reg  [DATA_W-1:0]     wr0_data,
    // Write-back port 1: high word of long multiplies
    output reg                   wr1_en,
    output reg  [REGNUM_W-1:0]   wr1_num,
    output reg  [DATA_W-1:0]     wr1_data,
    // Flag update strobes, never raised by this group
    output reg                   flags_wr_en,
    output reg                   ge_wr_en
);

    // Packed lane results
    wire [DATA_W-1:0]    hsub_byte_res;
    wire [DATA_W-1:0]    qadd_byte_res;
    wire [DATA_W-1:0]    hsub_half_res;
    wire [DATA_W-1:0]    qadd_half_res;
    wire [DATA_W-1:0]    xch_res;

    // Long multiply results
    wire [`DWORD_W-1:0]  prod;
    wire [`DWORD_W-1:0]  acc_pair;
    wire [`DWORD_W-1:0]  acc_low_ext;
    wire [`DWORD_W-1:0]  acc_high_ext;
    wire [`DWORD_W-1:0]  mul_long_res;
    wire [`DWORD_W-1:0]  mul_acc_res;
    wire [`DWORD_W-1:0]  mul_dacc_res;

    // Exchange halves
    wire [`HALF_W:0]     xch_sum;
    wire [`HALF_W:0]     xch_diff;

    // Next values of write-back port 0
    reg                  wr0_en_next;
    reg  [REGNUM_W-1:0]  wr0_num_next;
    reg  [DATA_W-1:0]    wr0_data_next;

    // Next values of write-back port 1
    reg                  wr1_en_next;
    reg  [REGNUM_W-1:0]  wr1_num_next;
    reg  [DATA_W-1:0]    wr1_data_next;

    // Decode results
    reg  [`DWORD_W-1:0]  long_res;
    reg                  is_long;
    reg                  is_packed;

    // Shared index of the lane generates
    genvar i;

    // Byte lanes: widen by one bit so borrow and carry survive
    generate
        for (i = 0; i < `BYTE_LANES; i = i + 1) begin : g_byte
            wire [`BYTE_W:0] bdiff;
            wire [`BYTE_W:0] bsum;
            // Difference for the halving subtract, borrow in bit eight
            assign bdiff = {1'b0, first_operand[i*`BYTE_W +: `BYTE_W]}
                         - {1'b0, second_operand[i*`BYTE_W +: `BYTE_W]};
            // Sum for the saturating add, carry in bit eight
            assign bsum  = {1'b0, first_operand[i*`BYTE_W +: `BYTE_W]}
                         + {1'b0, second_operand[i*`BYTE_W +: `BYTE_W]};
            // RULE_03: keep bits eight down to one
            assign hsub_byte_res[i*`BYTE_W +: `BYTE_W] = bdiff[`BYTE_W:1];
            // RULE_13: clamp on carry out
            assign qadd_byte_res[i*`BYTE_W +: `BYTE_W] =
                bsum[`BYTE_W] ? {`BYTE_W{1'b1}} : bsum[`BYTE_W-1:0];
        end
    endgenerate

    // Halfword lanes, same scheme at sixteen bits
    generate
        for (i = 0; i < `HALF_LANES; i = i + 1) begin : g_half
            wire [`HALF_W:0] hdiff;
            wire [`HALF_W:0] hsum;
            // Difference for the halving subtract, borrow in bit sixteen
            assign hdiff = {1'b0, first_operand[i*`HALF_W +: `HALF_W]}
                         - {1'b0, second_operand[i*`HALF_W +: `HALF_W]};
            // Sum for the saturating add, carry in bit sixteen
            assign hsum  = {1'b0, first_operand[i*`HALF_W +: `HALF_W]}
                         + {1'b0, second_operand[i*`HALF_W +: `HALF_W]};
            // RULE_02: halve the 17-bit difference
            assign hsub_half_res[i*`HALF_W +: `HALF_W] = hdiff[`HALF_W:1];
            // RULE_12: clamp on carry out
            assign qadd_half_res[i*`HALF_W +: `HALF_W] =
                hsum[`HALF_W] ? {`HALF_W{1'b1}} : hsum[`HALF_W-1:0];
        end
    endgenerate

    // RULE_01: crossed halves, sum low and difference high
    // Low half: first low plus second high, carry kept in bit sixteen
    assign xch_sum  = {1'b0, first_operand[`HALF_LO]} + {1'b0, second_operand[`HALF_HI]};
    // High half: first high minus second low, borrow kept in bit sixteen
    assign xch_diff = {1'b0, first_operand[`HALF_HI]} - {1'b0, second_operand[`HALF_LO]};
    // Dropping bit zero of each halves it
    assign xch_res  = {xch_diff[`HALF_W:1], xch_sum[`HALF_W:1]};

    // Single-cycle 32x32 multiplier; at 200 MHz this is the critical path
    // and a second stage would be the first thing to add if timing fails.
    assign prod         = first_operand * second_operand;
    // Prior destination pair, high word above low
    assign acc_pair     = {acc_high, acc_low};
    // Zero-extended single addends for the double accumulate
    assign acc_low_ext  = {{DATA_W{1'b0}}, acc_low};
    assign acc_high_ext = {{DATA_W{1'b0}}, acc_high};

    // RULE_07: bare product
    assign mul_long_res = prod;
    // RULE_06: 64-bit wrap-around accumulate
    assign mul_acc_res  = prod + acc_pair;
    // RULE_04: two 32-bit addends, never overflows 64 bits
    assign mul_dacc_res = prod + acc_low_ext + acc_high_ext;

    // Operation decode
    always @* begin
        // Defaults: packed result zero, plain product on the long path
        is_long   = 1'b0;
        is_packed = 1'b0;
        long_res  = mul_long_res;
        wr0_data_next = `WORD_RST;
        case (op_sel)
            // RULE_01: halving subtract and add with exchange
            `OP_HSUB_ADD_XCH: begin
                is_packed     = 1'b1;
                wr0_data_next = xch_res;
            end

            // RULE_02: halving subtract per halfword
            `OP_HSUB_HALF: begin
                is_packed     = 1'b1;
                wr0_data_next = hsub_half_res;
            end

            // RULE_03: halving subtract per byte
            `OP_HSUB_BYTE: begin
                is_packed     = 1'b1;
                wr0_data_next = hsub_byte_res;
            end

            // RULE_12: saturating add per halfword
            `OP_QADD_HALF: begin
                is_packed     = 1'b1;
                wr0_data_next = qadd_half_res;
            end

            // RULE_13: saturating add per byte
            `OP_QADD_BYTE: begin
                is_packed     = 1'b1;
                wr0_data_next = qadd_byte_res;
            end

            // RULE_04: product plus both prior words
            `OP_MUL_DACC_LONG: begin
                is_long  = 1'b1;
                long_res = mul_dacc_res;
            end

            // RULE_06: product plus prior pair
            `OP_MUL_ACC_LONG: begin
                is_long  = 1'b1;
                long_res = mul_acc_res;
            end

            // RULE_07: bare product
            `OP_MUL_LONG: begin
                is_long  = 1'b1;
                long_res = mul_long_res;
            end
            default: begin
                is_long   = 1'b0;
                is_packed = 1'b0;
            end
        endcase

        // RULE_05: low word on port 0, high word on port 1
        if (is_long) begin
            wr0_data_next = long_res[`DWORD_LO];
        end
        // Port 1 carries nothing for packed ops
        wr1_data_next = is_long ? long_res[`DWORD_HI] : `WORD_RST;
    end

    // Write enables and destination numbers
    always @* begin
        // Defaults: no write, numbers parked at zero
        wr0_en_next  = 1'b0;
        wr1_en_next  = 1'b0;
        wr0_num_next = `REGNUM_RST;
        wr1_num_next = `REGNUM_RST;
        // RULE_14: nothing is written unless the condition passed
        if (issue_valid && cond_passed) begin
            // RULE_15: packed ops touch only their one destination
            if (is_packed) begin
                wr0_en_next  = 1'b1;
                wr0_num_next = dest_reg;
            end

            // RULE_05: two destinations for the long forms
            // Decodes are exclusive, so the two ifs never both fire
            if (is_long) begin
                wr0_en_next  = 1'b1;
                wr0_num_next = dest_low_reg;
                wr1_en_next  = 1'b1;
                wr1_num_next = dest_high_reg;
            end
        end
    end

    // RULE_09: equal destination numbers are passed through as given;
    // both ports then name one register and the outcome is left to the file.
    // Registers 13 and 15 are not screened either: a check here would cost
    // a comparator per number for a case the issuer already excludes.

    // Write-back port 0; data is held at zero when no write is made
    always @(posedge core_clk) begin
        if (!nrst) begin
            wr0_en   <= 1'b0;
            wr0_num  <= `REGNUM_RST;
            wr0_data <= `WORD_RST;
        end else begin
            wr0_en   <= wr0_en_next;
            wr0_num  <= wr0_num_next;
            wr0_data <= wr0_en_next ? wr0_data_next : `WORD_RST;
        end
    end

    // Write-back port 1, used by the long multiplies only
    always @(posedge core_clk) begin
        if (!nrst) begin
            wr1_en   <= 1'b0;
            wr1_num  <= `REGNUM_RST;
            wr1_data <= `WORD_RST;
        end else begin
            wr1_en   <= wr1_en_next;
            wr1_num  <= wr1_num_next;
            wr1_data <= wr1_en_next ? wr1_data_next : `WORD_RST;
        end
    end

    // Flag strobes are registered so the outputs stay flop-driven
    always @(posedge core_clk) begin
        if (!nrst) begin
            flags_wr_en <= 1'b0;
            ge_wr_en    <= 1'b0;
        end else begin
            // RULE_08: long multiplies with flag setting fixed off
            // RULE_15: packed ops never update NZCV or GE
            flags_wr_en <= 1'b0;
            ge_wr_en    <= 1'b0;
        end
    end

endmodule // unsigned_simd_halving_multiply_alu

//--- testbench/alu_wb_chk.sv
/* Checker for write-back timing, numbers and long multiply results.
   Assumes it is bound to the datapath top; one clock, synchronous reset. */
`include "alu_defs.vh"
module alu_wb_chk #(
    parameter DATA_W   = 32,
    parameter REGNUM_W = 4
) (
    // Clock, reset and issue
    input logic                core_clk,
    input logic                nrst,
    input logic                issue_valid,
    input logic                cond_passed,
    input logic [2:0]          op_sel,
    input logic [DATA_W-1:0]   first_operand,
    input logic [DATA_W-1:0]   second_operand,
    input logic [DATA_W-1:0]   acc_low,
    input logic [DATA_W-1:0]   acc_high,
    input logic [REGNUM_W-1:0] dest_reg,
    input logic [REGNUM_W-1:0] dest_low_reg,
    input logic [REGNUM_W-1:0] dest_high_reg,
    // Write-back and flag strobes
    input logic                wr0_en,
    input logic [REGNUM_W-1:0] wr0_num,
    input logic [DATA_W-1:0]   wr0_data,
    input logic                wr1_en,
    input logic [REGNUM_W-1:0] wr1_num,
    input logic [DATA_W-1:0]   wr1_data,
    input logic                flags_wr_en,
    input logic                ge_wr_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Decode helpers, kept as nets so each property stays short
    wire taken   = nrst && issue_valid && cond_passed;
    wire is_long = (op_sel >= `OP_MUL_DACC_LONG) && (op_sel <= `OP_MUL_LONG);
    take_pulse_a: assert property (taken |=> wr0_en ##1 (!wr0_en || $past(taken))) else $error("no write pulse");
    idle_quiet_a: assert property (!taken |=> !wr0_en && !wr1_en) else $error("write without issue");
    long_hi_port_a: assert property (taken && is_long |=> wr1_en && wr1_num == $past(dest_high_reg))
        else $error("high word port wrong");
    long_lo_num_a: assert property (taken && is_long |=> wr0_num == $past(dest_low_reg))
        else $error("low word number wrong");
    packed_one_a: assert property (taken && !is_long |=> !wr1_en && wr0_num == $past(dest_reg))
        else $error("packed op wrote wrong port");
    flags_quiet_a: assert property (!flags_wr_en && !ge_wr_en) else $error("flag strobe raised");
    mul_plain_a: assert property (taken && op_sel == `OP_MUL_LONG |=>
        {wr1_data, wr0_data} == $past(first_operand) * $past(second_operand)) else $error("plain product");
    mul_acc_a: assert property (taken && op_sel == `OP_MUL_ACC_LONG |=> {wr1_data, wr0_data} ==
        $past(first_operand) * $past(second_operand) + {$past(acc_high), $past(acc_low)})
        else $error("accumulate long");
    mul_dacc_a: assert property (taken && op_sel == `OP_MUL_DACC_LONG |=> {wr1_data, wr0_data} ==
        $past(first_operand) * $past(second_operand) + $past(acc_high) + $past(acc_low))
        else $error("double accumulate");
endmodule // alu_wb_chk

bind unsigned_simd_halving_multiply_alu alu_wb_chk #(.DATA_W(DATA_W), .REGNUM_W(REGNUM_W)) chk (
    .core_clk(core_clk), .nrst(nrst), .issue_valid(issue_valid), .cond_passed(cond_passed), .op_sel(op_sel),
    .first_operand(first_operand), .second_operand(second_operand), .acc_low(acc_low), .acc_high(acc_high),
    .dest_reg(dest_reg), .dest_low_reg(dest_low_reg), .dest_high_reg(dest_high_reg), .wr0_en(wr0_en),
    .wr0_num(wr0_num), .wr0_data(wr0_data), .wr1_en(wr1_en), .wr1_num(wr1_num), .wr1_data(wr1_data),
    .flags_wr_en(flags_wr_en), .ge_wr_en(ge_wr_en));

//--- testbench/core_regfile_model.sv
/* Register file of the issuing core: absorbs write-backs, supplies prior
   destination contents. Assumes legal register numbers from the bench. */
module core_regfile_model (
    // Clock and reset
    input  logic        core_clk,
    input  logic        nrst,
    // Write-back from the datapath
    input  logic        wr0_en,
    input  logic [3:0]  wr0_num,
    input  logic [31:0] wr0_data,
    input  logic        wr1_en,
    input  logic [3:0]  wr1_num,
    input  logic [31:0] wr1_data,
    // Prior destination reads
    input  logic [3:0]  rd_low_num,
    input  logic [3:0]  rd_high_num,
    output logic [31:0] rd_low,
    output logic [31:0] rd_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [16];
    // Port 1 written last, as the high word wins on a clash
    always @(posedge core_clk) begin
        if (!nrst) begin
            foreach (regs[i]) regs[i] <= 32'h0;
        end else begin
            if (wr0_en) regs[wr0_num] <= wr0_data;
            if (wr1_en) regs[wr1_num] <= wr1_data;
        end
    end
    assign rd_low  = regs[rd_low_num];
    assign rd_high = regs[rd_high_num];
endmodule // core_regfile_model

//--- testbench/unsigned_simd_halving_multiply_alu_tb.sv
/* Self-checking bench: corner cases then random back-to-back issue.
   Assumes the datapath answers one cycle after the taking edge. */
`include "alu_defs.vh"
module unsigned_simd_halving_multiply_alu_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, nrst = 0, issue_valid = 0, cond_passed = 0, pend = 0, fixed = 1;
    logic [2:0]  op_sel = 0;
    logic [31:0] first_operand = 0, second_operand = 0;
    logic [3:0]  dest_reg = 0, dest_low_reg = 0, dest_high_reg = 1, en_n0, en_n1;
    wire  [31:0] acc_low, acc_high, wr0_data, wr1_data;
    wire  [3:0]  wr0_num, wr1_num;
    wire         wr0_en, wr1_en, flags_wr_en, ge_wr_en;
    logic [63:0] exp_r;
    logic        exp_c, exp_l;
    int          err_total = 0, num_checks = 0, cycles = 0;
    unsigned_simd_halving_multiply_alu dut (.core_clk, .nrst, .issue_valid, .cond_passed, .op_sel, .first_operand,
        .second_operand, .acc_low, .acc_high, .dest_reg, .dest_low_reg, .dest_high_reg, .wr0_en, .wr0_num,
        .wr0_data, .wr1_en, .wr1_num, .wr1_data, .flags_wr_en, .ge_wr_en);
    core_regfile_model rf (.core_clk, .nrst, .wr0_en, .wr0_num, .wr0_data, .wr1_en, .wr1_num, .wr1_data,
        .rd_low_num(dest_low_reg), .rd_high_num(dest_high_reg), .rd_low(acc_low), .rd_high(acc_high));
    initial forever #2.5 core_clk = ~core_clk;
    // Hang guard, well above the planned run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            finish_test();
        end
    end
    // Expected 64-bit result; packed ops fill the low word only
    function automatic logic [63:0] model(input logic [2:0] op, input logic [31:0] a, b, lo, hi);
        logic [16:0] s;
        logic [8:0]  t;
        logic [63:0] r;
        r = 64'h0;
        case (op)
            `OP_HSUB_ADD_XCH: begin
                s = a[15:0] + b[31:16];
                r[15:0] = s[16:1];
                s = a[31:16] - b[15:0];
                r[31:16] = s[16:1];
            end
            `OP_HSUB_HALF, `OP_QADD_HALF: for (int i = 0; i < 2; i++) begin
                s = (op == `OP_QADD_HALF) ? a[16*i+:16] + b[16*i+:16] : a[16*i+:16] - b[16*i+:16];
                r[16*i+:16] = (op == `OP_QADD_HALF) ? (s[16] ? 16'hFFFF : s[15:0]) : s[16:1];
            end
            `OP_HSUB_BYTE, `OP_QADD_BYTE: for (int i = 0; i < 4; i++) begin
                t = (op == `OP_QADD_BYTE) ? a[8*i+:8] + b[8*i+:8] : a[8*i+:8] - b[8*i+:8];
                r[8*i+:8] = (op == `OP_QADD_BYTE) ? (t[8] ? 8'hFF : t[7:0]) : t[8:1];
            end
            `OP_MUL_DACC_LONG: r = a * b + lo + hi;
            `OP_MUL_ACC_LONG: r = a * b + {hi, lo};
            default: r = a * b;
        endcase
        return r;
    endfunction
    task automatic cmp_bit(input string name, input logic exp, got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic cmp_word(input string name, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Pending result, due one edge after its issue; all zero around reset
    task automatic check_pend();
        if (pend) begin
            cmp_bit("wr0_en", exp_c, wr0_en);
            cmp_bit("wr1_en", exp_l, wr1_en);
            cmp_word("wr0_num", {28'h0, en_n0}, {28'h0, wr0_num});
            cmp_word("wr1_num", {28'h0, en_n1}, {28'h0, wr1_num});
            cmp_word("wr0_data", exp_r[31:0], wr0_data);
            cmp_word("wr1_data", exp_r[63:32], wr1_data);
            cmp_bit("flags_wr_en", 1'b0, flags_wr_en);
            cmp_bit("ge_wr_en", 1'b0, ge_wr_en);
        end
    endtask
    // Reset with issue held off; outputs checked clear in it and just after
    task automatic apply_reset(input int n);
        @(posedge core_clk);
        #1;
        check_pend();
        {nrst, issue_valid} = 2'h0;
        {exp_c, exp_l, exp_r, en_n0, en_n1, pend} = {2'h0, 64'h0, 8'h0, 1'b1};
        repeat (n) @(posedge core_clk);
        #1;
        nrst = 1;
        check_pend();
    endtask
    // One issue per cycle; the previous result is checked first
    task automatic step(input logic [2:0] op, input logic [31:0] a, b, input logic cp);
        @(posedge core_clk);
        #1;
        check_pend();
        dest_low_reg = fixed ? 4'h2 : 4'($urandom % 12);
        dest_high_reg = dest_low_reg + 4'h1;
        dest_reg = fixed ? 4'h4 : 4'($urandom % 13);
        {op_sel, first_operand, second_operand, issue_valid, cond_passed} = {op, a, b, 1'b1, cp};
        @(negedge core_clk);
        exp_l = cp && op >= `OP_MUL_DACC_LONG && op <= `OP_MUL_LONG;
        exp_c = cp;
        exp_r = cp ? model(op, a, b, acc_low, acc_high) : 64'h0;
        exp_r[63:32] = exp_l ? exp_r[63:32] : 32'h0;
        en_n0 = !cp ? 4'h0 : exp_l ? dest_low_reg : dest_reg;
        en_n1 = exp_l ? dest_high_reg : 4'h0;
        pend = 1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(34168));
        // Twelve edges in reset: the first one plus eleven more
        apply_reset(11);
        // Corners: borrow on both halfword lanes, all-ones sums just short of saturation, wrap of the 64-bit sum
        for (int k = 0; k < 16; k++) step(3'((k + 5) % 8), (k % 8 == 0 || k % 8 > 4) ? 32'hFFFFFFFF : 32'h0,
            32'hFFFFFFFF, k != 9);
        fixed = 0;
        repeat (200) step(3'($urandom % 8), $urandom, $urandom, ($urandom % 8) != 0);
        // Reset in mid-run, then random traffic again
        apply_reset(2);
        repeat (200) step(3'($urandom % 8), $urandom, $urandom, ($urandom % 8) != 0);
        step(3'h0, 32'h0, 32'h0, 1'b0);
        step(3'h0, 32'h0, 32'h0, 1'b0);
        finish_test();
    end
endmodule // unsigned_simd_halving_multiply_alu_tb
